//--- logic/safety_config_three.sv
// safety_config_three.sv: safety configuration register three with its
// write gating, reset-state re-initialisation and fail-count routing.
// assumes: spi framing, crc checking, the fail counters, the threshold
// registers and the device state machine all live outside on ref_clk.
`timescale 1ns/1ps
`include "safety_config_three_map.svh"

module safety_config_three
  import safety_config_three_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // spi command port
  input wire spi_cmd_s spi_cmd,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic write_done,
  output logic write_refused,
  // device state
  input wire dev_state_e dev_state,
  input wire logic config_lock,
  // fail counters and their reset thresholds
  input wire logic [CNT_W-1:0] watchdog_fail_counter,
  input wire logic [CNT_W-1:0] watchdog_fail_reset_threshold,
  input wire logic [CNT_W-1:0] error_monitor_fail_counter,
  input wire logic [CNT_W-1:0] error_monitor_reset_threshold,
  // configuration outputs
  output cfg3_fields_s fields,
  output logic [7:0] configuration_checksum_byte,
  // state transition requests
  output logic go_reset_state,
  output logic go_safe_state,
  output logic watchdog_reset_failure_flag
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  localparam int NCH = 2;
  localparam int CH_WD = 0;
  localparam int CH_ESM = 1;

  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  dev_state_e state_prev_reg;
  logic [7:0] read_data_reg;
  logic read_valid_reg;
  logic write_done_reg;
  logic write_refused_reg;

  logic write_open;
  logic write_take;
  logic write_drop;
  logic reset_entry;
  logic in_safe;
  logic wd_route_eff;
  logic [7:0] write_merge;
  logic [7:0] reset_merge;
  logic [7:0] cfg_visible;

  logic [CNT_W-1:0] ch_count [NCH];
  logic [CNT_W-1:0] ch_threshold [NCH];
  logic ch_armed [NCH];
  logic ch_route [NCH];
  logic [NCH-1:0] ch_go_reset;
  logic [NCH-1:0] ch_go_safe;

  // -----------------------------------------------------------------
  // write gating and state entry detection
  // -----------------------------------------------------------------
  // a write outside diagnostic state, or with the lock set, is dropped
  // but still answered so the host can see that it did not land
  assign write_open = (dev_state == ST_DIAG) && !config_lock;
  assign write_take = spi_cmd.write_config_three_command && write_open;
  assign write_drop = spi_cmd.write_config_three_command && !write_open;
  assign reset_entry = (dev_state == ST_RESET) &&
                       (state_prev_reg != ST_RESET);
  assign in_safe = (dev_state == ST_SAFE);

  // -----------------------------------------------------------------
  // next value of the register
  // -----------------------------------------------------------------
  // reserved bits are left out of the write mask and keep their stored value, zero from power-on
  assign write_merge = (cfg_reg & ~`CFG3_WRITE_MASK) |
                       (spi_cmd.data & `CFG3_WRITE_MASK);
  // the low four bits return to defaults; bits 6 and 4 keep their value
  assign reset_merge = (cfg_reg & ~`CFG3_RESET_INIT_MASK) |
                       (`CFG3_POR_VALUE & `CFG3_RESET_INIT_MASK);

  // writes cannot land in reset state, so the two sources never meet
  always_comb begin
    cfg_next = cfg_reg;
    if (reset_entry) begin
      cfg_next = reset_merge;
    end else if (write_take) begin
      cfg_next = write_merge;
    end
  end

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  // power-on reset and taken writes are the only things that clear bits 6 and 4
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `CFG3_POR_VALUE;
      state_prev_reg <= ST_OFF;
    end else begin
      cfg_reg <= cfg_next;
      state_prev_reg <= dev_state;
    end
  end

  // -----------------------------------------------------------------
  // spi answers
  // -----------------------------------------------------------------
  // reserved positions always read back zero
  assign cfg_visible = cfg_reg & `CFG3_WRITE_MASK;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data_reg <= `CFG3_ZERO;
      read_valid_reg <= 1'b0;
      write_done_reg <= 1'b0;
      write_refused_reg <= 1'b0;
    end else begin
      read_valid_reg <= spi_cmd.read_config_three_command;
      write_done_reg <= write_take;
      write_refused_reg <= write_drop;
      if (spi_cmd.read_config_three_command) begin
        read_data_reg <= cfg_visible;
      end
    end
  end

  assign read_data = read_data_reg;
  assign read_valid = read_valid_reg;
  assign write_done = write_done_reg;
  assign write_refused = write_refused_reg;

  // -----------------------------------------------------------------
  // configuration fields
  // -----------------------------------------------------------------
  // fields come straight from the register flops
  assign fields.spread_modulation_enable =
    cfg_reg[`CFG3_BIT_SPREAD];
  assign fields.spi_crc_enable = cfg_reg[`CFG3_BIT_SPI_CRC];
  assign fields.watchdog_answer_variant =
    cfg_reg[`CFG3_BIT_WD_VARIANT];
  assign fields.error_monitor_mode_select =
    cfg_reg[`CFG3_BIT_ESM_MODE];
  assign fields.watchdog_reset_routing = cfg_reg[`CFG3_BIT_WD_ROUTE];
  assign fields.error_monitor_reset_routing =
    cfg_reg[`CFG3_BIT_ESM_ROUTE];

  // the checksum engine outside covers the visible byte
  assign configuration_checksum_byte = cfg_visible;

  // -----------------------------------------------------------------
  // fail-count routing
  // -----------------------------------------------------------------
  // the stored routing bit survives the safe state; only its effect is
  // masked there so a later exit still sees the host's choice
  assign wd_route_eff = cfg_reg[`CFG3_BIT_WD_ROUTE] && !in_safe;

  // watchdog acts only in diagnostic or active state
  assign ch_count[CH_WD] = watchdog_fail_counter;
  assign ch_threshold[CH_WD] = watchdog_fail_reset_threshold;
  assign ch_armed[CH_WD] = (dev_state == ST_DIAG) ||
                           (dev_state == ST_ACTIVE);
  assign ch_route[CH_WD] = wd_route_eff;

  // error monitor also acts while already in safe state
  assign ch_count[CH_ESM] = error_monitor_fail_counter;
  assign ch_threshold[CH_ESM] = error_monitor_reset_threshold;
  assign ch_armed[CH_ESM] = (dev_state == ST_DIAG) ||
                            (dev_state == ST_ACTIVE) ||
                            (dev_state == ST_SAFE);
  assign ch_route[CH_ESM] = cfg_reg[`CFG3_BIT_ESM_ROUTE];

  // one watcher per fail counter
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_route
      fail_route #(
        .CNT_W(CNT_W)
      ) u_route (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .fail_count(ch_count[i]),
        .threshold(ch_threshold[i]),
        .armed(ch_armed[i]),
        .route_to_reset(ch_route[i]),
        .go_reset(ch_go_reset[i]),
        .go_safe(ch_go_safe[i])
      );
    end
  endgenerate

  // a reset request from either source outranks a safe request
  assign go_reset_state = |ch_go_reset;
  assign go_safe_state = (|ch_go_safe) && !(|ch_go_reset);

  // -----------------------------------------------------------------
  // watchdog reset-failure flag
  // -----------------------------------------------------------------
  // pulses with the routed transition; the sticky status lives outside
  assign watchdog_reset_failure_flag =
    ch_go_reset[CH_WD] || ch_go_safe[CH_WD];

endmodule

//--- shared/safety_config_three_map.svh
// safety_config_three_map.svh: bit positions, reset values and masks of the
// eight-bit safety configuration register three.
// assumes: included by bare name from modules that decode the register.
`ifndef SAFETY_CONFIG_THREE_MAP_SVH
`define SAFETY_CONFIG_THREE_MAP_SVH

// -------------------------------------------------------------------
// field positions
// -------------------------------------------------------------------
`define CFG3_BIT_RSVD7 7
`define CFG3_BIT_SPREAD 6
`define CFG3_BIT_RSVD5 5
`define CFG3_BIT_SPI_CRC 4
`define CFG3_BIT_WD_VARIANT 3
`define CFG3_BIT_ESM_MODE 2
`define CFG3_BIT_WD_ROUTE 1
`define CFG3_BIT_ESM_ROUTE 0

// -------------------------------------------------------------------
// reset values and masks
// -------------------------------------------------------------------
`define CFG3_POR_VALUE 8'h02
`define CFG3_WRITE_MASK 8'h5f
`define CFG3_RESET_INIT_MASK 8'h0f
`define CFG3_ZERO 8'h00
`define FAIL_TH_DEFAULT 4'hf

`endif

//--- shared/safety_config_three_pkg.sv
// safety_config_three_pkg.sv: types shared by the safety configuration block.
// assumes: the device state machine encodes its states as dev_state_e.
package safety_config_three_pkg;

  // -----------------------------------------------------------------
  // device operating states, driven by the outside state machine
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RESET = 3'b001,
    ST_DIAG = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_SAFE = 3'b100
  } dev_state_e;

  // -----------------------------------------------------------------
  // one decoded spi command aimed at this register
  // -----------------------------------------------------------------
  typedef struct packed {
    logic read_config_three_command;
    logic write_config_three_command;
    logic [7:0] data;
  } spi_cmd_s;

  // -----------------------------------------------------------------
  // live fields that steer the rest of the device
  // -----------------------------------------------------------------
  typedef struct packed {
    logic spread_modulation_enable;
    logic spi_crc_enable;
    logic watchdog_answer_variant;
    logic error_monitor_mode_select;
    logic watchdog_reset_routing;
    logic error_monitor_reset_routing;
  } cfg3_fields_s;

endpackage

//--- logic/fail_route.sv
// fail_route.sv: one fail-counter threshold watcher that turns a hit
// into a one-cycle request for the reset or the safe state.
// assumes: counter and threshold come from logic on ref_clk.
`timescale 1ns/1ps

module fail_route #(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // counter side
  input wire logic [CNT_W-1:0] fail_count,
  input wire logic [CNT_W-1:0] threshold,
  input wire logic armed,
  input wire logic route_to_reset,
  // requests
  output logic go_reset,
  output logic go_safe
);

  logic hit;
  logic hit_reg;
  logic go_reset_reg;
  logic go_safe_reg;
  logic first_hit;

  // a counter that saturates at its threshold must fire only once
  assign hit = armed && (fail_count >= threshold);
  assign first_hit = hit && !hit_reg;

  // requests are registered so the state machine sees clean pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_reg <= 1'b0;
      go_reset_reg <= 1'b0;
      go_safe_reg <= 1'b0;
    end else begin
      hit_reg <= hit;
      go_reset_reg <= first_hit && route_to_reset;
      go_safe_reg <= first_hit && !route_to_reset;
    end
  end

  assign go_reset = go_reset_reg;
  assign go_safe = go_safe_reg;

endmodule

//--- bench/safety_config_three_asserts.sv
// safety_config_three_asserts.sv: port checks on the config register.
// assumes: one ref_clk domain, bound to every register instance below.
`timescale 1ns/1ps
module safety_config_three_asserts
  import safety_config_three_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // command port
  input wire spi_cmd_s spi_cmd,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic write_done,
  input wire logic write_refused,
  // state and counters
  input wire dev_state_e dev_state,
  input wire logic config_lock,
  input wire logic [CNT_W-1:0] watchdog_fail_counter,
  input wire logic [CNT_W-1:0] watchdog_fail_reset_threshold,
  input wire logic [CNT_W-1:0] error_monitor_fail_counter,
  input wire logic [CNT_W-1:0] error_monitor_reset_threshold,
  // outputs under watch
  input wire cfg3_fields_s fields,
  input wire logic [7:0] configuration_checksum_byte,
  input wire logic go_reset_state,
  input wire logic go_safe_state,
  input wire logic watchdog_reset_failure_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // -----------------------------------------------------------------
  // helpers: hit windows follow the arming states of each channel
  // -----------------------------------------------------------------
  wire logic [7:0] cb = configuration_checksum_byte;
  wire logic wr = spi_cmd.write_config_three_command;
  wire logic open_wr = dev_state == ST_DIAG && !config_lock;
  wire logic wd_hit = dev_state inside {ST_DIAG, ST_ACTIVE} &&
    watchdog_fail_counter >= watchdog_fail_reset_threshold;
  wire logic em_hit = dev_state inside {ST_DIAG, ST_ACTIVE, ST_SAFE} &&
    error_monitor_fail_counter >= error_monitor_reset_threshold;
  wire logic wd_rt = fields.watchdog_reset_routing;
  wire logic em_rt = fields.error_monitor_reset_routing;

  property p_por; $rose(rst_n) |-> cb == 8'h02; endproperty
  a_por: assert property (p_por)
    else $error("register not at power-on value");
  property p_wr_ok;
    wr && open_wr |=> write_done && cb == ($past(spi_cmd.data) & 8'h5f);
  endproperty
  a_wr_ok: assert property (p_wr_ok)
    else $error("open write not taken");
  property p_wr_no;
    wr && !open_wr && $stable(dev_state) |=> write_refused && $stable(cb);
  endproperty
  a_wr_no: assert property (p_wr_no)
    else $error("closed write changed the register");
  property p_rsvd; cb[7] == 1'b0 && cb[5] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set");
  property p_fields; fields == {cb[6], cb[4:0]}; endproperty
  a_fields: assert property (p_fields)
    else $error("fields differ from register");
  property p_read;
    spi_cmd.read_config_three_command |=> read_valid && read_data == $past(cb);
  endproperty
  a_read: assert property (p_read)
    else $error("read answer wrong");
  property p_reinit;
    dev_state == ST_RESET && $past(dev_state) != ST_RESET
      |-> ##[1:2] cb[3:0] == 4'h2;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("low bits not restored on reset entry");
  property p_wd_rst;
    $rose(wd_hit) && wd_rt |=> go_reset_state && watchdog_reset_failure_flag;
  endproperty
  a_wd_rst: assert property (p_wd_rst)
    else $error("watchdog reset routing missed");
  property p_wd_safe;
    $past(rst_n) && $rose(wd_hit) && !wd_rt && !($rose(em_hit) && em_rt)
      |=> go_safe_state && !go_reset_state && watchdog_reset_failure_flag;
  endproperty
  a_wd_safe: assert property (p_wd_safe)
    else $error("watchdog safe routing missed");
  property p_em_rst; $rose(em_hit) && em_rt |=> go_reset_state; endproperty
  a_em_rst: assert property (p_em_rst)
    else $error("monitor reset routing missed");
  property p_em_safe;
    $past(rst_n) && $rose(em_hit) && !em_rt && !$rose(wd_hit)
      |=> go_safe_state && !go_reset_state;
  endproperty
  a_em_safe: assert property (p_em_safe)
    else $error("monitor safe routing missed");
  property p_quiet;
    $past(rst_n) && !$rose(wd_hit) && !$rose(em_hit) |=> !go_reset_state
      && !go_safe_state && !watchdog_reset_failure_flag;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("transition request without a new hit");
endmodule

bind safety_config_three safety_config_three_asserts #(.CNT_W(CNT_W)) u_chk (
  .ref_clk, .rst_n, .spi_cmd, .read_data, .read_valid, .write_done,
  .write_refused, .dev_state, .config_lock, .watchdog_fail_counter,
  .watchdog_fail_reset_threshold, .error_monitor_fail_counter,
  .error_monitor_reset_threshold, .fields, .configuration_checksum_byte,
  .go_reset_state, .go_safe_state, .watchdog_reset_failure_flag
);

//--- bench/host_cmd_model.sv
// host_cmd_model.sv: host side of the decoded spi command port.
// assumes: the bench calls wr and rd one at a time.
`timescale 1ns/1ps
module host_cmd_model
  import safety_config_three_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // answers
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic write_done,
  input wire logic write_refused,
  // commands
  output spi_cmd_s spi_cmd
);
  initial spi_cmd = '0;
  // one edge of command; idle data flips so stale bytes never match
  // returns on the edge that ends the answer pulse, so callers sample
  // the answer there and may drive inputs by non-blocking assignment
  task automatic send(input spi_cmd_s c, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    spi_cmd <= c;
    @(posedge ref_clk);
    spi_cmd <= {2'b00, ~c.data};
    @(posedge ref_clk);
  endtask
  // the caller picks the state; refusal outside diagnostic is expected
  task automatic wr(input logic [7:0] d, output logic [1:0] r, input int g);
    send({2'b01, d}, g);
    r = {write_done, write_refused};
  endtask
  task automatic rd(output logic [7:0] d, input int g);
    send({2'b10, 8'h00}, g);
    d = read_valid ? read_data : 8'hxx;
  endtask
endmodule

//--- bench/safety_config_three_test.sv
// safety_config_three_test.sv: access, lock, reset-entry and routing.
// assumes: host model drives commands, the checker is bound.
`timescale 1ns/1ps
module safety_config_three_test
  import safety_config_three_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  dev_state_e st = ST_OFF;
  logic lock = 1'b0;
  logic [3:0] wc = 4'h0;
  logic [3:0] ec = 4'h0;
  logic [3:0] th = 4'hf;
  spi_cmd_s cmd;
  logic [7:0] rdata;
  logic [7:0] cb;
  logic rv;
  logic wdn;
  logic wrf;
  logic gr;
  logic gs;
  logic wf;
  cfg3_fields_s f;
  int n_fail = 0;
  int check_count = 0;

  always #10 ref_clk = ~ref_clk;

  safety_config_three uut (.ref_clk(ref_clk), .rst_n(rst_n), .spi_cmd(cmd),
    .read_data(rdata), .read_valid(rv), .write_done(wdn),
    .write_refused(wrf), .dev_state(st), .config_lock(lock),
    .watchdog_fail_counter(wc), .watchdog_fail_reset_threshold(th),
    .error_monitor_fail_counter(ec), .error_monitor_reset_threshold(th),
    .fields(f), .configuration_checksum_byte(cb), .go_reset_state(gr),
    .go_safe_state(gs), .watchdog_reset_failure_flag(wf));
  host_cmd_model u_host (.ref_clk(ref_clk), .read_data(rdata),
    .read_valid(rv), .write_done(wdn), .write_refused(wrf), .spi_cmd(cmd));

  task automatic check(input string nm, input logic [7:0] s,
      input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done(input bit hung);
    if (hung) n_fail++;
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // count request pulses over a four-edge window, wider than the one-cycle latency that reset and safe requests share
  task automatic route(input bit em, input dev_state_e s,
      input logic [3:0] v, input logic [2:0] e);
    int nr;
    int ns;
    int nf;
    nr = 0;
    ns = 0;
    nf = 0;
    @(posedge ref_clk);
    st <= s;
    if (em) ec <= v;
    else wc <= v;
    repeat (4) begin
      @(posedge ref_clk);
      #1;
      nr += (gr === 1'b1);
      ns += (gs === 1'b1);
      nf += (wf === 1'b1);
    end
    @(posedge ref_clk);
    wc <= 4'h0;
    ec <= 4'h0;
    check("go_reset", 8'(nr), {7'b0, e[2]});
    check("go_safe", 8'(ns), {7'b0, e[1]});
    check("wd_flag", 8'(nf), {7'b0, e[0]});
  endtask

  initial #100000 test_done(1'b1);

  // main sequence
  initial begin
    logic [7:0] r;
    logic [7:0] v;
    logic [1:0] a;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    u_host.rd(r, 0);
    check("por", r, 8'h02);
    st <= ST_DIAG;
    for (int i = 0; i < 8; i++) begin
      v = (8'h01 << i) & 8'h5f;
      u_host.wr(8'h01 << i, a, i % 2);
      check("wr_resp", {6'b0, a}, 8'h02);
      u_host.rd(r, 0);
      check("cfg", r, v);
      check("fields", {2'b00, f}, {2'b00, v[6], v[4:0]});
    end
    u_host.wr(8'hff, a, 0);
    lock <= 1'b1;
    u_host.wr(8'h00, a, 0);
    check("locked", {6'b0, a}, 8'h01);
    lock <= 1'b0;
    st <= ST_ACTIVE;
    u_host.wr(8'h00, a, 1);
    check("active", {6'b0, a}, 8'h01);
    u_host.rd(r, 0);
    check("kept", r, 8'h5f);
    check("checksum", cb, 8'h5f);
    st <= ST_RESET;
    repeat (3) @(posedge ref_clk);
    u_host.rd(r, 0);
    check("reinit", r, 8'h52);
    route(1'b0, ST_ACTIVE, 4'he, 3'b000);
    route(1'b0, ST_ACTIVE, 4'hf, 3'b101);
    route(1'b1, ST_DIAG, 4'hf, 3'b010);
    route(1'b0, ST_SAFE, 4'hf, 3'b000);
    route(1'b1, ST_SAFE, 4'hf, 3'b010);
    u_host.rd(r, 0);
    check("masked", r, 8'h52);
    st <= ST_DIAG;
    u_host.wr(8'h01, a, 1);
    route(1'b0, ST_DIAG, 4'hf, 3'b011);
    route(1'b1, ST_ACTIVE, 4'hf, 3'b100);
    test_done(1'b0);
  end
endmodule
